//--- src/sfc_pkg.sv
package sfc_pkg;

    localparam logic [7:0] OP_LATCH_SET    = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_CONFIG_READ  = 8'h15;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_SUSPEND_A    = 8'h75;
    localparam logic [7:0] OP_SUSPEND_B    = 8'hB0;
    localparam logic [7:0] OP_RESUME_A     = 8'h7A;
    localparam logic [7:0] OP_RESUME_B     = 8'h30;
    localparam logic [7:0] OP_POWER_DOWN   = 8'hB9;
    localparam logic [7:0] OP_IDENT_READ   = 8'h9F;
    localparam logic [7:0] OP_LEGACY_SIG   = 8'hAB;
    localparam logic [7:0] OP_MAKER_DEV    = 8'h90;
    localparam logic [7:0] OP_OTP_ENTER    = 8'hB1;
    localparam logic [7:0] OP_OTP_EXIT     = 8'hC1;
    localparam logic [7:0] OP_SEC_READ     = 8'h2B;
    localparam logic [7:0] OP_SEC_WRITE    = 8'h2F;
    localparam logic [7:0] OP_RESET_ARM    = 8'h66;
    localparam logic [7:0] OP_RESET_FIRE   = 8'h99;

    // Identification values, arbitrary
    localparam logic [7:0] MAKER_ID        = 8'h5A;
    localparam logic [7:0] DEV_ID_HI       = 8'h3C;
    localparam logic [7:0] DEV_ID_LO       = 8'h11;

    localparam logic [7:0] MAKER_DEVICE_ID_CMD_DEV_FIRST  = 8'h01;
    localparam logic [2:0] LEN_ONE         = 3'h1;
    localparam logic [2:0] LEN_STATUS_WR   = 3'h3;
    localparam logic [2:0] START_SHORT     = 3'h1;
    localparam logic [2:0] START_LONG      = 3'h4;
    localparam logic [2:0] LAST_BIT        = 3'h7;
    localparam logic [2:0] MAX_BYTES       = 3'h7;
    localparam logic [1:0] IDENT_LAST      = 2'h2;
    localparam logic [1:0] MAKER_DEVICE_ID_CMD_LAST       = 2'h1;
    localparam int         WIP_BIT         = 0;
    localparam int         WEL_BIT         = 1;
    localparam logic [7:0] STATUS_WR_MASK  = 8'hFC;
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    localparam int         SEC_LOCK_BIT    = 1;
    localparam int         SEC_OTP_BIT     = 0;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] arg1;
        logic [7:0] arg2;
        logic [7:0] arg3;
        logic [2:0] byteCnt;
        logic [2:0] bitCnt;
    } sfc_frame_t;

endpackage

//--- src/sfc_cmd_decoder.sv
`timescale 1ns/100ps
module sfc_cmd_decoder
    import sfc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       sclkLink,
    input  wire logic       csN,
    input  wire logic       serialIn,
    input  wire logic [2:0] upperIo,
    input  wire logic       progBusy,
    input  wire logic       progDone,
    output logic            serialOut,
    output logic            serialOutEnN,
    output logic            writeEnableLatch,
    output logic [7:0]      statusReg,
    output logic [7:0]      configReg,
    output logic [7:0]      securityReg,
    output logic            opSuspended,
    output logic            otpMode,
    output logic            powerDown,
    output logic            softResetPulse
);

    // Link domain
    sfc_frame_t frame_reg;
    logic       fresh_reg;
    logic       frameTag_reg;
    logic [7:0] shift_reg;
    logic [1:0] outSel_reg;
    logic       identBlock_reg;
    logic       serialOut_reg;
    logic       serialOutEnN_reg;
    logic       linkClear;
    logic [2:0] curBit;
    logic [2:0] curByte;
    logic [7:0] shiftNext;
    logic [7:0] opNow;
    logic [2:0] startIdx;
    logic [7:0] txByte;
    logic       txActive;

    // System domain
    logic [2:0] csSync_reg;
    logic       csHigh_reg;
    logic [2:0] tagSync_reg;
    logic       tagSeen_reg;
    logic       frameEnd_reg;
    sfc_frame_t snap_reg;
    logic       wel_reg;
    logic [7:0] statusBits_reg;
    logic [7:0] statusView_reg;
    logic [7:0] configReg_reg;
    logic       secLock_reg;
    logic [7:0] secView_reg;
    logic       suspended_reg;
    logic       otp_reg;
    logic       powerDown_reg;
    logic       armed_reg;
    logic       softReset_reg;
    logic       busyView_reg;
    logic       csAgreeHigh;
    logic       exec;
    logic       ok1;
    logic       ok3;
    logic       cmdSet;
    logic       cmdClear;
    logic       cmdSuspend;
    logic       cmdStatusWr;
    logic       cmdFire;

    assign linkClear = csN | ~reset_n;

    always_comb
    begin
        curBit    = fresh_reg ? 3'h0 : frame_reg.bitCnt;
        curByte   = fresh_reg ? 3'h0 : frame_reg.byteCnt;
        shiftNext = {(fresh_reg ? 7'h00 : shift_reg[6:0]), serialIn};
        opNow     = (curByte == 3'h0) ? shiftNext : frame_reg.opcode;
        startIdx  = (opNow == OP_LEGACY_SIG || opNow == OP_MAKER_DEV) ? START_LONG : START_SHORT;
    end

    // Frame start marker, set while deselected
    always_ff @(posedge sclkLink or posedge linkClear)
    begin
        if (linkClear)
            fresh_reg <= 1'b1;
        else
            fresh_reg <= 1'b0;
    end

    // Input capture on rising edges
    always_ff @(posedge sclkLink or negedge reset_n)
    begin
        if (!reset_n)
        begin
            frame_reg    <= '0;
            shift_reg    <= RESET_BYTE;
            frameTag_reg <= 1'b0;
        end
        else
        begin
            if (fresh_reg)
                frameTag_reg <= ~frameTag_reg;
            shift_reg        <= shiftNext;
            frame_reg.bitCnt <= curBit + 3'h1;
            frame_reg.byteCnt <= curByte;
            if (curBit == LAST_BIT)
            begin
                unique case (curByte)
                    3'h0:    frame_reg.opcode <= shiftNext;
                    3'h1:    frame_reg.arg1 <= shiftNext;
                    3'h2:    frame_reg.arg2 <= shiftNext;
                    3'h3:    frame_reg.arg3 <= shiftNext;
                    default: ;
                endcase
                if (curByte != MAX_BYTES)
                    frame_reg.byteCnt <= curByte + 3'h1;
            end
        end
    end

    // Output byte selector and ident gating
    always_ff @(posedge sclkLink or negedge reset_n)
    begin
        if (!reset_n)
        begin
            outSel_reg     <= 2'h0;
            identBlock_reg <= 1'b0;
        end
        else if (curBit == LAST_BIT)
        begin
            if (curByte == 3'h0)
                identBlock_reg <= busyView_reg;
            if (curByte + 3'h1 == startIdx)
                outSel_reg <= (opNow == OP_MAKER_DEV && shiftNext == MAKER_DEVICE_ID_CMD_DEV_FIRST) ? 2'h1 : 2'h0;
            else if (opNow == OP_IDENT_READ)
                outSel_reg <= (outSel_reg == IDENT_LAST) ? 2'h0 : outSel_reg + 2'h1;
            else if (opNow == OP_MAKER_DEV)
                outSel_reg <= (outSel_reg == MAKER_DEVICE_ID_CMD_LAST) ? 2'h0 : outSel_reg + 2'h1;
        end
    end

    always_comb
    begin
        txByte = RESET_BYTE;
        unique case (frame_reg.opcode)
            OP_STATUS_READ: txByte = statusView_reg;
            OP_CONFIG_READ: txByte = configReg_reg;
            OP_SEC_READ:    txByte = secView_reg;
            OP_IDENT_READ:  txByte = (outSel_reg == 2'h0) ? MAKER_ID :
                                     (outSel_reg == 2'h1) ? DEV_ID_HI : DEV_ID_LO;
            OP_LEGACY_SIG:  txByte = DEV_ID_LO;
            OP_MAKER_DEV:   txByte = (outSel_reg == 2'h0) ? MAKER_ID : DEV_ID_LO;
            default:        txByte = RESET_BYTE;
        endcase
        txActive = !fresh_reg && frame_reg.byteCnt >= startIdxOf(frame_reg.opcode)
                   && isReadOp(frame_reg.opcode)
                   && !(frame_reg.opcode == OP_IDENT_READ && identBlock_reg)
                   && !(powerDown_reg && frame_reg.opcode != OP_LEGACY_SIG);
    end

    function automatic logic isReadOp(input logic [7:0] op);
        isReadOp = op == OP_STATUS_READ || op == OP_CONFIG_READ || op == OP_SEC_READ
                   || op == OP_IDENT_READ || op == OP_LEGACY_SIG || op == OP_MAKER_DEV;
    endfunction

    function automatic logic [2:0] startIdxOf(input logic [7:0] op);
        startIdxOf = (op == OP_LEGACY_SIG || op == OP_MAKER_DEV) ? START_LONG : START_SHORT;
    endfunction

    // Output on falling edges, released on deselect
    always_ff @(negedge sclkLink or posedge linkClear)
    begin
        if (linkClear)
        begin
            serialOut_reg    <= 1'b0;
            serialOutEnN_reg <= 1'b1;
        end
        else
        begin
            serialOut_reg    <= txByte[LAST_BIT - frame_reg.bitCnt];
            serialOutEnN_reg <= !txActive;
        end
    end

    assign serialOut    = serialOut_reg;
    assign serialOutEnN = serialOutEnN_reg;

    // Select and frame tag crossing
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            csSync_reg   <= 3'h7;
            csHigh_reg   <= 1'b1;
            tagSync_reg  <= 3'h0;
            tagSeen_reg  <= 1'b0;
            frameEnd_reg <= 1'b0;
            snap_reg     <= '0;
        end
        else
        begin
            csSync_reg   <= {csSync_reg[1:0], csN};
            tagSync_reg  <= {tagSync_reg[1:0], frameTag_reg};
            frameEnd_reg <= 1'b0;
            if (csAgreeHigh && !csHigh_reg)
            begin
                csHigh_reg   <= 1'b1;
                frameEnd_reg <= tagSync_reg[2] != tagSeen_reg;
                tagSeen_reg  <= tagSync_reg[2];
                snap_reg     <= frame_reg;
            end
            else if (!csSync_reg[1] && !csSync_reg[2])
                csHigh_reg <= 1'b0;
        end
    end

    assign csAgreeHigh = csSync_reg[1] && csSync_reg[2];

    always_comb
    begin
        exec        = frameEnd_reg && (!powerDown_reg || snap_reg.opcode == OP_LEGACY_SIG);
        ok1         = exec && snap_reg.bitCnt == 3'h0 && snap_reg.byteCnt == LEN_ONE;
        ok3         = exec && snap_reg.bitCnt == 3'h0 && snap_reg.byteCnt == LEN_STATUS_WR;
        cmdSet      = ok1 && snap_reg.opcode == OP_LATCH_SET;
        cmdClear    = ok1 && snap_reg.opcode == OP_LATCH_CLEAR;
        cmdStatusWr = ok3 && snap_reg.opcode == OP_STATUS_WRITE && wel_reg;
        cmdSuspend  = ok1 && progBusy && !suspended_reg
                      && (snap_reg.opcode == OP_SUSPEND_A || snap_reg.opcode == OP_SUSPEND_B);
        cmdFire     = ok1 && snap_reg.opcode == OP_RESET_FIRE && armed_reg;
    end

    // Write enable latch, set wins over clear
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            wel_reg <= 1'b0;
        else if (cmdSet)
            wel_reg <= 1'b1;
        else if (cmdClear || cmdStatusWr || cmdSuspend || cmdFire || progDone
                 || (ok1 && snap_reg.opcode == OP_SEC_WRITE))
            wel_reg <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            statusBits_reg <= RESET_BYTE;
            configReg_reg  <= RESET_BYTE;
        end
        else if (cmdStatusWr)
        begin
            statusBits_reg <= snap_reg.arg1 & STATUS_WR_MASK;
            configReg_reg  <= snap_reg.arg2;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            suspended_reg <= 1'b0;
            otp_reg       <= 1'b0;
            powerDown_reg <= 1'b0;
            armed_reg     <= 1'b0;
            softReset_reg <= 1'b0;
            secLock_reg   <= 1'b0;
        end
        else
        begin
            softReset_reg <= cmdFire;
            if (exec)
                armed_reg <= ok1 && snap_reg.opcode == OP_RESET_ARM;
            if (cmdSuspend)
                suspended_reg <= 1'b1;
            else if (cmdFire || (ok1 && (snap_reg.opcode == OP_RESUME_A
                                          || snap_reg.opcode == OP_RESUME_B)))
                suspended_reg <= 1'b0;
            if (ok1 && snap_reg.opcode == OP_OTP_ENTER)
                otp_reg <= 1'b1;
            else if (cmdFire || (ok1 && snap_reg.opcode == OP_OTP_EXIT))
                otp_reg <= 1'b0;
            if (ok1 && snap_reg.opcode == OP_POWER_DOWN)
                powerDown_reg <= 1'b1;
            else if (exec && snap_reg.opcode == OP_LEGACY_SIG)
                powerDown_reg <= 1'b0;
            if (ok1 && snap_reg.opcode == OP_SEC_WRITE)
                secLock_reg <= 1'b1;
        end
    end

    // Views read by the link side; refreshed on every system clock, so WIP follows progBusy && !suspended_reg mid-frame, while busy is sampled once at the opcode byte
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            statusView_reg <= RESET_BYTE;
            secView_reg    <= RESET_BYTE;
            busyView_reg   <= 1'b0;
        end
        else
        begin
            statusView_reg          <= statusBits_reg;
            statusView_reg[WIP_BIT] <= progBusy && !suspended_reg;
            statusView_reg[WEL_BIT] <= wel_reg;
            secView_reg               <= RESET_BYTE;
            secView_reg[SEC_LOCK_BIT] <= secLock_reg;
            secView_reg[SEC_OTP_BIT]  <= otp_reg;
            busyView_reg            <= progBusy && !suspended_reg;
        end
    end

    assign writeEnableLatch = wel_reg;
    assign statusReg        = statusView_reg;
    assign configReg        = configReg_reg;
    assign securityReg      = secView_reg;
    assign opSuspended      = suspended_reg;
    assign otpMode          = otp_reg;
    assign powerDown        = powerDown_reg;
    assign softResetPulse   = softReset_reg;

    property p_latch_set;
        @(posedge sys_clk) disable iff (!reset_n) cmdSet |=> wel_reg ##1 statusView_reg[WEL_BIT];
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch not set");

    property p_latch_clear;
        @(posedge sys_clk) disable iff (!reset_n) cmdClear |=> !wel_reg;
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

    property p_done_clears;
        @(posedge sys_clk) disable iff (!reset_n) (progDone || cmdFire) && !cmdSet |=> !wel_reg;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("latch kept");

    property p_status_write;
        @(posedge sys_clk) disable iff (!reset_n)
            cmdStatusWr |=> configReg_reg == $past(snap_reg.arg2) && !wel_reg;
    endproperty
    a_status_write: assert property (p_status_write) else $error("status write lost");

    property p_suspend;
        @(posedge sys_clk) disable iff (!reset_n) cmdSuspend |=> suspended_reg ##1 !statusView_reg[WIP_BIT];
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend missed");

    property p_otp_enter;
        @(posedge sys_clk) disable iff (!reset_n)
            ok1 && snap_reg.opcode == OP_OTP_ENTER |=> otp_reg;
    endproperty
    a_otp_enter: assert property (p_otp_enter) else $error("otp not entered");

    property p_otp_exit;
        @(posedge sys_clk) disable iff (!reset_n)
            ok1 && snap_reg.opcode == OP_OTP_EXIT |=> !otp_reg;
    endproperty
    a_otp_exit: assert property (p_otp_exit) else $error("otp not left");

    property p_fire_needs_arm;
        @(posedge sys_clk) disable iff (!reset_n) softReset_reg |-> $past(armed_reg) && $past(exec);
    endproperty
    a_fire_needs_arm: assert property (p_fire_needs_arm) else $error("reset without arm");

    property p_boundary;
        @(posedge sys_clk) disable iff (!reset_n)
            frameEnd_reg && snap_reg.bitCnt != 3'h0 && !progDone |=> $stable(wel_reg);
    endproperty
    a_boundary: assert property (p_boundary) else $error("partial byte accepted");

    property p_lock_sticky;
        @(posedge sys_clk) disable iff (!reset_n) secLock_reg |=> secLock_reg;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");

    property p_ident_quiet;
        @(negedge sclkLink) disable iff (linkClear)
            frame_reg.opcode == OP_IDENT_READ && identBlock_reg |=> serialOutEnN_reg;
    endproperty
    a_ident_quiet: assert property (p_ident_quiet) else $error("ident while busy");

    c_status_write: cover property (@(posedge sys_clk) disable iff (!reset_n) cmdStatusWr);
    c_soft_reset:   cover property (@(posedge sys_clk) disable iff (!reset_n) cmdFire);
    c_suspend:      cover property (@(posedge sys_clk) disable iff (!reset_n) cmdSuspend);

endmodule

//--- verif/sfc_host_model.sv
`timescale 1ns/100ps
module sfc_host_model
(
    output logic      csN,
    output logic      sclkLink,
    output logic      serialIn,
    input  wire logic serialOut,
    input  wire logic serialOutEnN
);
    logic [7:0] rxByte;
    logic       sawDrive;
    event       rxDone;

    initial
    begin
        csN = 1'b1;
        sclkLink = 1'b0;
        serialIn = 1'b0;
        rxByte = 8'h00;
        sawDrive = 1'b0;
    end

    // Mode 0 frame; clock stands low between frames
    task automatic frame(input logic [31:0] tx, input int nTx, input int nRd,
                         input int extra, input realtime half);
        int i;
        sawDrive = 1'b0;
        csN = 1'b0;
        #(half);
        for (i = 0; i < nTx * 8 + extra; i++)
        begin
            serialIn = (i < nTx * 8) ? tx[31 - i] : ~serialIn;
            #(half) sclkLink = 1'b1;
            #(half) sclkLink = 1'b0;
        end
        for (i = 0; i < nRd * 8; i++)
        begin
            serialIn = ~serialIn;
            #(half) sclkLink = 1'b1;
            sawDrive = sawDrive | (serialOutEnN === 1'b0);
            rxByte = {rxByte[6:0], (serialOutEnN === 1'b0) ? serialOut : 1'bx};
            if (i % 8 == 7)
                ->rxDone;
            #(half) sclkLink = 1'b0;
        end
        #(half) csN = 1'b1;
        serialIn = ~serialIn;
        #60;
    endtask
endmodule

//--- verif/serial_flash_setting_id_commands_test.sv
`timescale 1ns/100ps
module serial_flash_setting_id_commands_test
    import sfc_pkg::*;
;
    logic        sys_clk, reset_n, csN, sclkLink, serialIn, progBusy, progDone;
    logic [2:0]  upperIo;
    logic        serialOut, serialOutEnN, writeEnableLatch;
    logic        opSuspended, otpMode, powerDown, softResetPulse;
    logic [7:0]  statusReg, configReg, securityReg, s, c;
    logic [31:0] rnd;
    logic [7:0]  expQ[$];
    int          failures, checked, pulses, i;

    sfc_cmd_decoder dut (.sys_clk(sys_clk), .reset_n(reset_n), .sclkLink(sclkLink),
        .csN(csN), .serialIn(serialIn), .upperIo(upperIo), .progBusy(progBusy),
        .progDone(progDone), .serialOut(serialOut), .serialOutEnN(serialOutEnN),
        .writeEnableLatch(writeEnableLatch), .statusReg(statusReg),
        .configReg(configReg), .securityReg(securityReg), .opSuspended(opSuspended),
        .otpMode(otpMode), .powerDown(powerDown), .softResetPulse(softResetPulse));

    sfc_host_model host (.csN(csN), .sclkLink(sclkLink), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEnN(serialOutEnN));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wrap_up;
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic run(input logic [31:0] tx, input int nTx, input int nRd = 0,
                       input int extra = 0);
        host.frame(tx, nTx, nRd, extra, 3.0);
        repeat (8) @(posedge sys_clk);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        progBusy = 1'b0;
        progDone = 1'b0;
        upperIo = 3'h0;
        rnd = 32'h31F7;
        failures = 0;
        checked = 0;
        pulses = 0;
    end

    always #5 sys_clk = ~sys_clk;

    // Upper lines carry noise throughout
    always @(posedge sys_clk)
    begin
        rnd <= lfsr(rnd);
        upperIo <= rnd[2:0];
    end

    // Pulse counted where it is settled
    always @(negedge sys_clk)
    begin
        if (softResetPulse === 1'b1)
            pulses++;
    end

    always @(host.rxDone)
    begin
        if (expQ.size() == 0)
            chk("spare", 8'h00, 8'hFF);
        else
            chk("rx", expQ.pop_front(), host.rxByte);
    end

    initial
    begin
        #500000;
        failures++;
        wrap_up();
    end

    initial
    begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("latch", 8'h00, 8'(writeEnableLatch));
        chk("oe", 8'h01, 8'(serialOutEnN));
        run({OP_LATCH_SET, 24'h0}, 1);
        chk("latch", 8'h01, 8'(writeEnableLatch));
        expQ.push_back(8'h02);
        expQ.push_back(8'h02);
        run({OP_STATUS_READ, 24'h0}, 1, 2);
        run({OP_LATCH_CLEAR, 24'h0}, 1);
        chk("latch", 8'h00, 8'(writeEnableLatch));
        run({OP_LATCH_SET, 24'h0}, 1, 0, 3);
        run({OP_LATCH_SET, 24'h0}, 2);
        chk("latch", 8'h00, 8'(writeEnableLatch));
        s = rnd[7:0];
        c = rnd[15:8];
        run({OP_LATCH_SET, 24'h0}, 1);
        run({OP_STATUS_WRITE, s, c, 8'h00}, 3);
        chk("status", {s[7:2], 2'b00}, {statusReg[7:2], 2'b00});
        chk("config", c, configReg);
        expQ.push_back(c);
        run({OP_CONFIG_READ, 24'h0}, 1, 1);
        @(posedge sys_clk) progDone <= 1'b1;
        @(posedge sys_clk) progDone <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("latch", 8'h00, 8'(writeEnableLatch));
        run({OP_STATUS_WRITE, ~s, ~c, 8'h00}, 3);
        chk("config", c, configReg);
        expQ.push_back(MAKER_ID);
        expQ.push_back(DEV_ID_HI);
        expQ.push_back(DEV_ID_LO);
        expQ.push_back(MAKER_ID);
        run({OP_IDENT_READ, 24'h0}, 1, 4);
        expQ.push_back(MAKER_ID);
        run({OP_IDENT_READ, 24'h0}, 1, 1);
        chk("oe", 8'h01, 8'(serialOutEnN));
        @(posedge sys_clk) progBusy <= 1'b1;
        expQ.push_back(8'hXX);
        run({OP_IDENT_READ, 24'h0}, 1, 1);
        chk("drive", 8'h00, 8'(host.sawDrive));
        for (i = 0; i < 2; i++)
        begin
            run({OP_LATCH_SET, 24'h0}, 1);
            run({i ? OP_SUSPEND_B : OP_SUSPEND_A, 24'h0}, 1);
            chk("susp", 8'h01, 8'(opSuspended));
            chk("latch", 8'h00, 8'(writeEnableLatch));
            run({i ? OP_RESUME_B : OP_RESUME_A, 24'h0}, 1);
            chk("susp", 8'h00, 8'(opSuspended));
        end
        @(posedge sys_clk) progBusy <= 1'b0;
        expQ.push_back(DEV_ID_LO);
        expQ.push_back(DEV_ID_LO);
        run({OP_LEGACY_SIG, rnd[23:0]}, 4, 2);
        for (i = 0; i < 2; i++)
        begin
            expQ.push_back(i ? DEV_ID_LO : MAKER_ID);
            expQ.push_back(i ? MAKER_ID : DEV_ID_LO);
            expQ.push_back(i ? DEV_ID_LO : MAKER_ID);
            run({OP_MAKER_DEV, 16'hFFFF, 8'(i)}, 4, 3);
        end
        run({OP_OTP_ENTER, 24'h0}, 1);
        chk("otp", 8'h01, 8'(otpMode));
        expQ.push_back(8'h01);
        run({OP_SEC_READ, 24'h0}, 1, 1);
        run({OP_OTP_EXIT, 24'h0}, 1);
        chk("otp", 8'h00, 8'(otpMode));
        run({OP_LATCH_SET, 24'h0}, 1);
        run({OP_SEC_WRITE, 24'h0}, 1);
        chk("latch", 8'h00, 8'(writeEnableLatch));
        run({OP_LATCH_SET, 24'h0}, 1);
        run({OP_RESET_ARM, 24'h0}, 1);
        expQ.push_back({s[7:2], 2'b10});
        run({OP_STATUS_READ, 24'h0}, 1, 1);
        run({OP_RESET_FIRE, 24'h0}, 1);
        chk("pulses", 8'h00, 8'(pulses));
        chk("latch", 8'h01, 8'(writeEnableLatch));
        run({OP_RESET_ARM, 24'h0}, 1);
        run({OP_RESET_FIRE, 24'h0}, 1);
        chk("pulses", 8'h01, 8'(pulses));
        chk("latch", 8'h00, 8'(writeEnableLatch));
        chk("lock", 8'h01, 8'(securityReg[SEC_LOCK_BIT]));
        run({OP_POWER_DOWN, 24'h0}, 1);
        chk("pd", 8'h01, 8'(powerDown));
        run({OP_LATCH_SET, 24'h0}, 1);
        chk("latch", 8'h00, 8'(writeEnableLatch));
        run({OP_LEGACY_SIG, 24'h0}, 1);
        chk("pd", 8'h00, 8'(powerDown));
        chk("queue", 8'h00, 8'(expQ.size()));
        wrap_up();
    end
endmodule
